// file: common/hall_regs_pkg.sv
/*
 * shared constants and carriers for the hall result and wake-up register bank.
 * assumes a byte-wide register port driven by a bus engine on the same clock.
 */
package hall_regs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_FIELD_X_HIGH   = 8'h00;
	localparam logic [7:0] OFS_FIELD_Y_HIGH   = 8'h01;
	localparam logic [7:0] OFS_FIELD_Z_HIGH   = 8'h02;
	localparam logic [7:0] OFS_HEAT_HIGH      = 8'h03;
	localparam logic [7:0] OFS_FIELD_XY_LOW   = 8'h04;
	localparam logic [7:0] OFS_HEAT_Z_LOW     = 8'h05;
	localparam logic [7:0] OFS_DIAG           = 8'h06;
	localparam logic [7:0] OFS_X_LOWER_HIGH   = 8'h07;
	localparam logic [7:0] OFS_X_UPPER_HIGH   = 8'h08;
	localparam logic [7:0] OFS_Y_LOWER_HIGH   = 8'h09;
	localparam logic [7:0] OFS_Y_UPPER_HIGH   = 8'h0a;
	localparam logic [7:0] OFS_Z_LOWER_HIGH   = 8'h0b;
	localparam logic [7:0] OFS_Z_UPPER_HIGH   = 8'h0c;
	localparam logic [7:0] OFS_WAKE_X_LOW     = 8'h0d;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_FIELD_HIGH     = 8'h00;
	localparam logic [7:0] RST_HEAT_HIGH      = 8'h80;
	localparam logic [3:0] RST_NIBBLE         = 4'h0;
	localparam logic [1:0] RST_HEAT_LOW       = 2'h0;
	localparam logic [7:0] RST_LIMIT_HIGH     = 8'h00;
	localparam logic [2:0] RST_LIMIT_LOW      = 3'h0;
	localparam logic [7:0] READ_UNMAPPED      = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int WAKE_ACT_BIT  = 7;
	localparam int WAKE_EN_BIT   = 6;
	localparam int UP_LSB_HI     = 5;
	localparam int UP_LSB_LO     = 3;
	localparam int LO_LSB_HI     = 2;
	localparam int LO_LSB_LO     = 0;
	localparam int DIAG_RES_PAR  = 7;
	localparam int DIAG_CFG_PAR  = 6;

	// width of a full axis result
	localparam int AXIS_W        = 12;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic        valid;
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] z;
		logic [9:0]  heat;
	} sample_s;

	typedef struct packed {
		logic [7:0]  high;
		logic [2:0]  low;
	} limit_s;

endpackage : hall_regs_pkg

// file: rtl/hall_axis_window.sv
/*
 * one axis threshold comparator: full signed result against both limits.
 * assumes result and limits are stable for the cycle they are compared.
 */
`timescale 1ns/1ps
module hall_axis_window #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// operands
	input  wire logic [W-1:0] i_value,
	input  wire logic [W-1:0] i_lower,
	input  wire logic [W-1:0] i_upper,
	// result
	output logic              o_hit
);

	// signed compares; limits built as high part above low bits
	wire logic at_or_below = $signed(i_value) <= $signed(i_lower);
	wire logic at_or_above = $signed(i_value) >= $signed(i_upper);

	// registered so the top output stays flop-driven
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hit <= 1'b0;
		end else begin
			o_hit <= at_or_below | at_or_above;
		end
	end

endmodule : hall_axis_window

// file: rtl/hall_result_wakeup_regs.sv
/*
 * hall sensor result and wake-up threshold register bank.
 * assumes a same-clock byte register port from the bus engine and conversion
 * samples arriving as one valid-qualified struct.
 */
`timescale 1ns/1ps
module hall_result_wakeup_regs #(
	parameter int AW = 8
) (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// register port
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	input  wire logic [AW-1:0]          i_addr,
	input  wire logic [7:0]             i_wdata,
	output logic      [7:0]             o_rdata,
	// conversion samples
	input  wire hall_regs_pkg::sample_s i_sample,
	input  wire logic                   i_z_on,
	input  wire logic                   i_heat_on,
	// straps and diagnostic inputs
	input  wire logic [1:0]             i_bus_address_selector,
	input  wire logic                   i_result_parity,
	input  wire logic                   i_config_parity_flag,
	input  wire logic                   i_config_register_parity,
	input  wire logic                   i_test_mode_on,
	input  wire logic [5:0]             i_diag_rest,
	input  wire logic [2:0]             i_y_limit_low_up,
	input  wire logic [2:0]             i_y_limit_low_lo,
	input  wire logic [2:0]             i_z_limit_low_up,
	input  wire logic [2:0]             i_z_limit_low_lo,
	// interrupt
	input  wire logic                   i_ordinary_int,
	output logic                        o_int_pulse,
	output logic                        o_wake_active_flag
);

	////////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0]  x_high_ff, y_high_ff, z_high_ff, heat_high_ff;
	logic [3:0]  x_nib_ff, y_nib_ff, z_nib_ff;
	logic [1:0]  heat_low_ff;
	logic [1:0]  addr_sel_ff;
	hall_regs_pkg::limit_s x_lower_limit_ff, x_upper_limit_ff;
	hall_regs_pkg::limit_s y_lower_limit_ff, y_upper_limit_ff;
	hall_regs_pkg::limit_s z_lower_limit_ff, z_upper_limit_ff;
	logic        wake_enable_ff;
	logic        wake_active_flag_ff;
	logic [7:0]  rdata_ff;
	logic        int_ff;
	logic        hit_seen_ff;

	////////////////////////////////////////////////////////////////////////////
	// write decode
	wire logic wr_xl = i_wr && (i_addr == hall_regs_pkg::OFS_X_LOWER_HIGH);
	wire logic wr_xh = i_wr && (i_addr == hall_regs_pkg::OFS_X_UPPER_HIGH);
	wire logic wr_yl = i_wr && (i_addr == hall_regs_pkg::OFS_Y_LOWER_HIGH);
	wire logic wr_yh = i_wr && (i_addr == hall_regs_pkg::OFS_Y_UPPER_HIGH);
	wire logic wr_zl = i_wr && (i_addr == hall_regs_pkg::OFS_Z_LOWER_HIGH);
	wire logic wr_zh = i_wr && (i_addr == hall_regs_pkg::OFS_Z_UPPER_HIGH);
	wire logic wr_wu = i_wr && (i_addr == hall_regs_pkg::OFS_WAKE_X_LOW);

	////////////////////////////////////////////////////////////////////////////
	// sample capture: z and heat fall back to reset values while switched off
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			x_high_ff    <= hall_regs_pkg::RST_FIELD_HIGH;
			y_high_ff    <= hall_regs_pkg::RST_FIELD_HIGH;
			x_nib_ff     <= hall_regs_pkg::RST_NIBBLE;
			y_nib_ff     <= hall_regs_pkg::RST_NIBBLE;
		end else if (i_sample.valid) begin
			x_high_ff    <= i_sample.x[11:4];
			y_high_ff    <= i_sample.y[11:4];
			x_nib_ff     <= i_sample.x[3:0];
			y_nib_ff     <= i_sample.y[3:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			z_high_ff    <= hall_regs_pkg::RST_FIELD_HIGH;
			z_nib_ff     <= hall_regs_pkg::RST_NIBBLE;
		end else if (!i_z_on) begin
			z_high_ff    <= hall_regs_pkg::RST_FIELD_HIGH;
			z_nib_ff     <= hall_regs_pkg::RST_NIBBLE;
		end else if (i_sample.valid) begin
			z_high_ff    <= i_sample.z[11:4];
			z_nib_ff     <= i_sample.z[3:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			heat_high_ff <= hall_regs_pkg::RST_HEAT_HIGH;
			heat_low_ff  <= hall_regs_pkg::RST_HEAT_LOW;
		end else if (!i_heat_on) begin
			heat_high_ff <= hall_regs_pkg::RST_HEAT_HIGH;
			heat_low_ff  <= hall_regs_pkg::RST_HEAT_LOW;
		end else if (i_sample.valid) begin
			heat_high_ff <= i_sample.heat[9:2];
			heat_low_ff  <= i_sample.heat[1:0];
		end
	end

	// selector copy is caught after reset release, never loaded under reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			addr_sel_ff <= 2'h0;
		end else begin
			addr_sel_ff <= i_bus_address_selector;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// threshold registers, high parts written whole
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			x_lower_limit_ff.high <= hall_regs_pkg::RST_LIMIT_HIGH;
			x_upper_limit_ff.high <= hall_regs_pkg::RST_LIMIT_HIGH;
			y_lower_limit_ff.high <= hall_regs_pkg::RST_LIMIT_HIGH;
			y_upper_limit_ff.high <= hall_regs_pkg::RST_LIMIT_HIGH;
			z_lower_limit_ff.high <= hall_regs_pkg::RST_LIMIT_HIGH;
			z_upper_limit_ff.high <= hall_regs_pkg::RST_LIMIT_HIGH;
		end else begin
			if (wr_xl) x_lower_limit_ff.high <= i_wdata;
			if (wr_xh) x_upper_limit_ff.high <= i_wdata;
			if (wr_yl) y_lower_limit_ff.high <= i_wdata;
			if (wr_yh) y_upper_limit_ff.high <= i_wdata;
			if (wr_zl) z_lower_limit_ff.high <= i_wdata;
			if (wr_zh) z_upper_limit_ff.high <= i_wdata;
		end
	end

	// y and z low bits live in registers outside this bank
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			y_lower_limit_ff.low <= hall_regs_pkg::RST_LIMIT_LOW;
			y_upper_limit_ff.low <= hall_regs_pkg::RST_LIMIT_LOW;
			z_lower_limit_ff.low <= hall_regs_pkg::RST_LIMIT_LOW;
			z_upper_limit_ff.low <= hall_regs_pkg::RST_LIMIT_LOW;
		end else begin
			y_lower_limit_ff.low <= i_y_limit_low_lo;
			y_upper_limit_ff.low <= i_y_limit_low_up;
			z_lower_limit_ff.low <= i_z_limit_low_lo;
			z_upper_limit_ff.low <= i_z_limit_low_up;
		end
	end

	// x low bits and wake enable share one register; bit 7 ignores writes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			x_upper_limit_ff.low <= hall_regs_pkg::RST_LIMIT_LOW;
			x_lower_limit_ff.low <= hall_regs_pkg::RST_LIMIT_LOW;
			wake_enable_ff       <= 1'b0;
		end else if (wr_wu) begin
			x_upper_limit_ff.low <= i_wdata[hall_regs_pkg::UP_LSB_HI:hall_regs_pkg::UP_LSB_LO];
			x_lower_limit_ff.low <= i_wdata[hall_regs_pkg::LO_LSB_HI:hall_regs_pkg::LO_LSB_LO];
			wake_enable_ff       <= i_wdata[hall_regs_pkg::WAKE_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wake-up qualification: enable alone is only a request
	wire logic wake_ok = wake_enable_ff && !i_test_mode_on
		&& i_config_register_parity && i_config_parity_flag;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wake_active_flag_ff <= 1'b0;
		end else begin
			wake_active_flag_ff <= wake_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-axis comparators on full 12-bit values
	wire logic [hall_regs_pkg::AXIS_W-1:0] axis_val [3];
	wire logic [hall_regs_pkg::AXIS_W-1:0] axis_lo  [3];
	wire logic [hall_regs_pkg::AXIS_W-1:0] axis_up  [3];
	wire logic [2:0]                       axis_hit;

	// low limit bits pad with zero to reach the nibble position
	assign axis_val[0] = {x_high_ff, x_nib_ff};
	assign axis_val[1] = {y_high_ff, y_nib_ff};
	assign axis_val[2] = {z_high_ff, z_nib_ff};
	assign axis_lo[0]  = {x_lower_limit_ff, 1'b0};
	assign axis_lo[1]  = {y_lower_limit_ff, 1'b0};
	assign axis_lo[2]  = {z_lower_limit_ff, 1'b0};
	assign axis_up[0]  = {x_upper_limit_ff, 1'b0};
	assign axis_up[1]  = {y_upper_limit_ff, 1'b0};
	assign axis_up[2]  = {z_upper_limit_ff, 1'b0};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			hall_axis_window #(
				.W       (hall_regs_pkg::AXIS_W)
			) u_window (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_value (axis_val[g]),
				.i_lower (axis_lo[g]),
				.i_upper (axis_up[g]),
				.o_hit   (axis_hit[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// interrupt: with wake active, one pulse per new sample that crosses a limit; otherwise follows the ordinary source
	wire logic any_hit = |axis_hit;
	logic      sample_d_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sample_d_ff <= 1'b0;
			hit_seen_ff <= 1'b0;
		end else begin
			sample_d_ff <= i_sample.valid;
			hit_seen_ff <= sample_d_ff;
		end
	end

	// comparators lag the sample by two cycles, hence the delayed strobe
	wire logic wake_pulse = wake_active_flag_ff && hit_seen_ff && any_hit;
	wire logic nxt_int    = wake_active_flag_ff ? wake_pulse : i_ordinary_int;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_ff <= 1'b0;
		end else begin
			int_ff <= nxt_int;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux
	logic [7:0] rd_mux;

	always_comb begin
		unique case (i_addr)
			hall_regs_pkg::OFS_FIELD_X_HIGH: rd_mux = x_high_ff;
			hall_regs_pkg::OFS_FIELD_Y_HIGH: rd_mux = y_high_ff;
			hall_regs_pkg::OFS_FIELD_Z_HIGH: rd_mux = z_high_ff;
			hall_regs_pkg::OFS_HEAT_HIGH:    rd_mux = heat_high_ff;
			hall_regs_pkg::OFS_FIELD_XY_LOW: rd_mux = {x_nib_ff, y_nib_ff};
			hall_regs_pkg::OFS_HEAT_Z_LOW:   rd_mux = {heat_low_ff, addr_sel_ff, z_nib_ff};
			hall_regs_pkg::OFS_DIAG:         rd_mux = {i_result_parity, i_config_parity_flag, i_diag_rest};
			hall_regs_pkg::OFS_X_LOWER_HIGH: rd_mux = x_lower_limit_ff.high;
			hall_regs_pkg::OFS_X_UPPER_HIGH: rd_mux = x_upper_limit_ff.high;
			hall_regs_pkg::OFS_Y_LOWER_HIGH: rd_mux = y_lower_limit_ff.high;
			hall_regs_pkg::OFS_Y_UPPER_HIGH: rd_mux = y_upper_limit_ff.high;
			hall_regs_pkg::OFS_Z_LOWER_HIGH: rd_mux = z_lower_limit_ff.high;
			hall_regs_pkg::OFS_Z_UPPER_HIGH: rd_mux = z_upper_limit_ff.high;
			hall_regs_pkg::OFS_WAKE_X_LOW:   rd_mux = {wake_active_flag_ff, wake_enable_ff,
				x_upper_limit_ff.low, x_lower_limit_ff.low};
			default:                         rd_mux = hall_regs_pkg::READ_UNMAPPED;
		endcase
	end

	// read data registered and held until the next read
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= hall_regs_pkg::READ_UNMAPPED;
		end else if (i_rd) begin
			rdata_ff <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_rdata            = rdata_ff;
	assign o_int_pulse        = int_ff;
	assign o_wake_active_flag = wake_active_flag_ff;

endmodule : hall_result_wakeup_regs

// file: sim/hall_regs_monitor.sv
/* port checker for the hall result and wake-up register bank.
 * assumes it is bound to the bank and shares its clock and reset. */
`timescale 1ns/1ps
module hall_regs_monitor #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	// register port
	input wire logic                   i_rd,
	input wire logic [AW-1:0]          i_addr,
	input wire logic [7:0]             o_rdata,
	// samples, straps, diagnostics
	input wire hall_regs_pkg::sample_s i_sample,
	input wire logic                   i_z_on,
	input wire logic                   i_heat_on,
	input wire logic [1:0]             i_bus_address_selector,
	input wire logic                   i_result_parity,
	input wire logic                   i_config_parity_flag,
	input wire logic                   i_config_register_parity,
	input wire logic                   i_test_mode_on,
	input wire logic [5:0]             i_diag_rest,
	// interrupt
	input wire logic                   i_ordinary_int,
	input wire logic                   o_int_pulse,
	input wire logic                   o_wake_active_flag
);
	////////////////////////////////////////
	// all checks on the bank clock, quiet in reset
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_heat; !i_heat_on [*3] ##0 (i_rd && i_addr == hall_regs_pkg::OFS_HEAT_HIGH) |=> o_rdata == 8'h80; endproperty
	a_heat: assert property (p_heat)
		else $error("heat high not at reset value while off");
	property p_z; !i_z_on [*3] ##0 (i_rd && i_addr == hall_regs_pkg::OFS_FIELD_Z_HIGH) |=> o_rdata == 8'h00; endproperty
	a_z: assert property (p_z)
		else $error("z high not at reset value while off");
	property p_unmapped; i_rd && i_addr > hall_regs_pkg::OFS_WAKE_X_LOW |=> o_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_diag; i_rd && i_addr == hall_regs_pkg::OFS_DIAG
		|=> o_rdata == $past({i_result_parity, i_config_parity_flag, i_diag_rest}); endproperty
	a_diag: assert property (p_diag)
		else $error("parity flags misplaced in diag read");
	property p_sel; i_rd && i_addr == hall_regs_pkg::OFS_HEAT_Z_LOW && $stable(i_bus_address_selector) && !$past(i_rst)
		|=> o_rdata[5:4] == $past(i_bus_address_selector); endproperty
	a_sel: assert property (p_sel)
		else $error("selector copy wrong");
	property p_wa_read; i_rd && i_addr == hall_regs_pkg::OFS_WAKE_X_LOW |=> o_rdata[7] == $past(o_wake_active_flag); endproperty
	a_wa_read: assert property (p_wa_read)
		else $error("wake flag bit disagrees with flag output");
	property p_wake_rise; $rose(o_wake_active_flag)
		|-> $past(!i_test_mode_on && i_config_register_parity && i_config_parity_flag); endproperty
	a_wake_rise: assert property (p_wake_rise)
		else $error("wake became active without its conditions");
	property p_wake_drop; i_test_mode_on |=> !o_wake_active_flag; endproperty
	a_wake_drop: assert property (p_wake_drop)
		else $error("wake active in test mode");
	property p_ordinary; !o_wake_active_flag && $past(!o_wake_active_flag) && !$past(i_rst)
		|-> o_int_pulse == $past(i_ordinary_int); endproperty
	a_ordinary: assert property (p_ordinary)
		else $error("interrupt does not follow ordinary source");
	property p_wake_int; o_int_pulse && $past(o_wake_active_flag) |-> $past(i_sample.valid, 3); endproperty
	a_wake_int: assert property (p_wake_int)
		else $error("wake pulse without a sample");
endmodule : hall_regs_monitor

bind hall_result_wakeup_regs hall_regs_monitor #(.AW(AW)) hall_regs_monitor_inst (
	.i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd), .i_addr(i_addr), .o_rdata(o_rdata), .i_sample(i_sample),
	.i_z_on(i_z_on), .i_heat_on(i_heat_on), .i_bus_address_selector(i_bus_address_selector),
	.i_result_parity(i_result_parity), .i_config_parity_flag(i_config_parity_flag),
	.i_config_register_parity(i_config_register_parity), .i_test_mode_on(i_test_mode_on),
	.i_diag_rest(i_diag_rest), .i_ordinary_int(i_ordinary_int), .o_int_pulse(o_int_pulse),
	.o_wake_active_flag(o_wake_active_flag));

// file: sim/hall_host_model.sv
/* host bus master model driving the bank register port.
 * assumes the bank clock; the bench calls its tasks. */
`timescale 1ns/1ps
module hall_host_model (
	// clock and read data
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	// register port requests
	output logic            o_wr,
	output logic            o_rd,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata
);
	////////////////////////////////////////
	// idle port at time zero
	initial begin
		{o_wr, o_rd, o_addr, o_wdata} = '0;
	end
	// one byte write; released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		{o_wr, o_addr, o_wdata} <= {1'b1, a, d};
		@(posedge i_clk);
		{o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~d};
	endtask : wr
	// one byte read, data taken once settled; each read in a burst captures the register on its own cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		{o_rd, o_addr} <= {1'b1, a};
		@(posedge i_clk);
		{o_rd, o_addr} <= {1'b0, ~a};
		@(negedge i_clk);
		d = i_rdata;
	endtask : rd
endmodule : hall_host_model

// file: sim/hall_result_wakeup_regs_bench.sv
/* self-checking bench for the hall register bank against an integer model.
 * assumes the host model and the bound port checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module hall_result_wakeup_regs_bench;
	logic i_clk, i_rst, i_wr, i_rd, i_z_on, i_heat_on, i_result_parity, i_config_parity_flag;
	logic i_config_register_parity, i_test_mode_on, i_ordinary_int, o_int_pulse, o_wake_active_flag;
	logic [7:0] i_addr, i_wdata, o_rdata, rd_val;
	logic [1:0] i_bus_address_selector;
	logic [5:0] i_diag_rest;
	logic [2:0] i_y_limit_low_up, i_y_limit_low_lo, i_z_limit_low_up, i_z_limit_low_lo;
	hall_regs_pkg::sample_s i_sample;
	int fail_count, check_count, mdl[14], zl, hl, x, u, l, v[4];

	////////////////////////////////////////
	hall_result_wakeup_regs #(.AW(8)) hall_result_wakeup_regs_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr),
		.i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_sample(i_sample), .i_z_on(i_z_on),
		.i_heat_on(i_heat_on), .i_bus_address_selector(i_bus_address_selector), .i_result_parity(i_result_parity),
		.i_config_parity_flag(i_config_parity_flag), .i_config_register_parity(i_config_register_parity),
		.i_test_mode_on(i_test_mode_on), .i_diag_rest(i_diag_rest), .i_y_limit_low_up(i_y_limit_low_up),
		.i_y_limit_low_lo(i_y_limit_low_lo), .i_z_limit_low_up(i_z_limit_low_up), .i_z_limit_low_lo(i_z_limit_low_lo),
		.i_ordinary_int(i_ordinary_int), .o_int_pulse(o_int_pulse), .o_wake_active_flag(o_wake_active_flag));
	hall_host_model hall_host_model_inst (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
		.o_addr(i_addr), .o_wdata(i_wdata));

	// 10 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	////////////////////////////////////////
	// signed 12-bit value and a limit built as high part, three low bits, zero bit
	function automatic int sx(int a);
		return (a & 12'h800) ? (a & 12'hfff) - 4096 : (a & 12'hfff);
	endfunction : sx
	function automatic int lim(int h, int b);
		return sx(h * 16 + b * 2);
	endfunction : lim
	function automatic logic hit(int xv, int yv, int zv);
		return sx(xv) <= lim(mdl[7], mdl[13] & 7) || sx(xv) >= lim(mdl[8], mdl[13] >> 3 & 7)
			|| sx(yv) <= lim(mdl[9], i_y_limit_low_lo) || sx(yv) >= lim(mdl[10], i_y_limit_low_up)
			|| sx(zv) <= lim(mdl[11], i_z_limit_low_lo) || sx(zv) >= lim(mdl[12], i_z_limit_low_up);
	endfunction : hit
	task automatic rd_chk(input int a, input int e);
		hall_host_model_inst.rd(8'(a), rd_val);
		`CHK(rd_val, 8'(e))
	endtask : rd_chk
	// whole map in one burst, each register captured on its own read cycle
	task automatic check_all();
		mdl[5] = hl * 64 + i_bus_address_selector * 16 + zl;
		mdl[6] = {i_result_parity, i_config_parity_flag, i_diag_rest};
		for (int a = 0; a < 14; a++) rd_chk(a, mdl[a]);
	endtask : check_all
	// sample pulse, then settle to the cycle the wake pulse is due
	task automatic send();
		@(posedge i_clk);
		i_sample <= {1'b1, 12'(v[0]), 12'(v[1]), 12'(v[2]), 10'(v[3])};
		@(posedge i_clk);
		i_sample.valid <= 1'b0;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
	endtask : send
	task automatic wait_flag(input logic f);
		int n;
		for (n = 0; n < 10 && o_wake_active_flag !== f; n++) @(negedge i_clk);
		if (o_wake_active_flag !== f) begin
			fail_count++;
			$display("Error %0t: wake flag wait ran out", $time);
			results();
		end
	endtask : wait_flag
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'hc5e1));
		{i_rst, i_z_on, i_heat_on, i_test_mode_on, i_config_register_parity, i_config_parity_flag} = 6'h3f;
		{i_result_parity, i_diag_rest, i_bus_address_selector, i_ordinary_int} = 10'($urandom) & 10'h3fe;
		{i_y_limit_low_up, i_y_limit_low_lo, i_z_limit_low_up, i_z_limit_low_lo} = 12'($urandom);
		i_sample = '0;
		mdl = '{3: 128, default: 0};
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		check_all();
		rd_chk(8'h20, 0);
		$display("test reset_values done");
		// writes everywhere; only thresholds and the wake enable take them
		for (int a = 0; a < 14; a++) begin
			x = $urandom & 255;
			hall_host_model_inst.wr(8'(a), 8'(x));
			if (a > 6) mdl[a] = (a == 13) ? x & 8'h7f : x;
		end
		check_all();
		`CHK(o_wake_active_flag, 1'b0)
		$display("test access done");
		// results with z and heat switched off in turn
		for (int n = 0; n < 4; n++) begin
			@(posedge i_clk);
			{i_z_on, i_heat_on, i_bus_address_selector} <= {n != 2, n != 3, 2'(n)};
			foreach (v[k]) v[k] = $urandom & 12'hfff;
			send();
			{mdl[0], mdl[1], mdl[4]} = {v[0] >> 4, v[1] >> 4, (v[0] & 15) * 16 + (v[1] & 15)};
			{mdl[2], zl} = (n != 2) ? {v[2] >> 4, v[2] & 15} : {32'h0, 32'h0};
			{mdl[3], hl} = (n != 3) ? {(v[3] & 10'h3ff) >> 2, v[3] & 3} : {32'd128, 32'h0};
			check_all();
		end
		$display("test results done");
		for (int n = 0; n < 8; n++) begin
			@(posedge i_clk);
			i_ordinary_int <= n[0];
			@(posedge i_clk);
			@(negedge i_clk);
			`CHK(o_int_pulse, n[0])
		end
		$display("test ordinary_int done");
		@(posedge i_clk);
		{i_ordinary_int, i_z_on, i_heat_on, i_test_mode_on} <= 4'b0110;
		for (int a = 7; a < 13; a++) begin
			mdl[a] = a[0] ? 8'hc0 : 8'h40;
			hall_host_model_inst.wr(8'(a), 8'(mdl[a]));
		end
		hall_host_model_inst.rd(8'h0d, rd_val);
		x = (rd_val & 8'h80) | 8'h40 | ($urandom & 8'h3f);
		hall_host_model_inst.wr(8'h0d, 8'(x));
		mdl[13] = (x & 8'h7f) | 8'h80;
		wait_flag(1'b1);
		rd_chk(13, mdl[13]);
		u = lim(mdl[8], mdl[13] >> 3 & 7);
		l = lim(mdl[7], mdl[13] & 7);
		// limits exactly, one inside each, then random fields
		for (int n = 0; n < 24; n++) begin
			v[0] = (n == 0) ? u : (n == 1) ? l : (n == 2) ? u - 1 : (n == 3) ? l + 1 : $urandom;
			v[1] = (n < 12) ? $urandom_range(255) : $urandom;
			v[2] = $urandom_range(255);
			v[3] = $urandom;
			send();
			`CHK(o_int_pulse, hit(v[0], v[1], v[2]))
		end
		// each parity qualifier alone must take the wake flag down
		for (int n = 0; n < 2; n++) begin
			@(posedge i_clk);
			{i_config_parity_flag, i_config_register_parity} <= n[0] ? 2'b10 : 2'b01;
			wait_flag(1'b0);
			`CHK(o_wake_active_flag, 1'b0)
			@(posedge i_clk);
			{i_config_parity_flag, i_config_register_parity} <= 2'b11;
			wait_flag(1'b1);
		end
		@(posedge i_clk);
		i_test_mode_on <= 1'b1;
		wait_flag(1'b0);
		`CHK(o_wake_active_flag, 1'b0)
		$display("test wake done");
		results();
	end
endmodule : hall_result_wakeup_regs_bench
